// *** ppc_pkg.sv ***
/*
 * Shared constants and types for the profile position command word block.
 * Assumes one 50 MHz clock and a synchronous active high reset everywhere.
 */
package ppc_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [15:0] CTRL_WORD_INDEX = 16'h6040; // Object index of the word
    localparam logic [15:0] CTRL_WORD_RESET = 16'h0000;

    // ==========================================================
    // Bit positions of the control word
    // ==========================================================
    localparam int BIT_START     = 4;
    localparam int BIT_IMMEDIATE = 5;
    localparam int BIT_RELATIVE  = 6;
    localparam int BIT_HALT      = 8;
    localparam int BIT_UNSUP     = 9;  // Stored, never read by logic
    localparam int BIT_RESERVED  = 10; // Stored, never read by logic
    localparam int BIT_REL_BASE  = 12;
    localparam int BIT_PUSH      = 13;
    localparam int BIT_WRAP      = 14;

    // ==========================================================
    // Timing
    // ==========================================================
    // Start after halt release needs more than two communication cycles
    localparam int          HALT_GUARD_COMM_CYCLES = 2;
    localparam logic [1:0]  HALT_GUARD_DONE        = 2'(HALT_GUARD_COMM_CYCLES + 1);
    localparam logic [1:0]  HALT_GUARD_RESET       = 2'h0;

    // ==========================================================
    // Types
    // ==========================================================
    // Motor current selection handed to the current loop
    typedef enum logic [1:0] {
        PPC_CUR_STOP = 2'b00,
        PPC_CUR_RUN  = 2'b01,
        PPC_CUR_PUSH = 2'b10
    } ppc_cur_t;

    // One positioning command
    typedef struct packed {
        logic        wrap;
        logic        push;
        logic        relative;
        logic        relActual;
        logic [1:0]  wrapMode;
        logic [31:0] dest;
    } ppc_cmd_t;

    // Positions fed from the profile generator and the encoder
    typedef struct packed {
        logic [31:0] target;
        logic [31:0] commanded;
        logic [31:0] actual;
    } ppc_pos_t;

endpackage : ppc_pkg

// *** ppc_sync.sv ***
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes clk, rst as in the rest of the block; output is the second flop.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic asyncIn,
    output var  logic syncOut
);

    logic meta_r;

    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    // First flop feeds only the second one
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule : ppc_sync

`default_nettype wire

// *** ppc_command_word.sv ***
/*
 * Control word interpreter for profile position mode: decodes the 16-bit
 * word written by the fieldbus master, detects the start strobe, queues or
 * replaces moves and drives the set-point acknowledge.
 * Assumes the word arrives on a write strobe in this clock domain, the
 * profile generator pulses moveDone when a move ends, and the stop input
 * is an unsynchronised pin.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Wrap bit at start gives wrap absolute move; relative bit 6 still applies
// - Push bit at start gives push-motion move
// - Halt or stop ends push; stop current
// - Incremental base zero adds to commanded position
// - Incremental base one adds to actual position
// - Halt bit stops motion by halt option
// - Relative clear: target is absolute destination
// - Relative set: target is travel distance
// - Immediate clear: start while moving is queued
// - Immediate set: start while moving replaces
// - Start bit rising edge starts configured move
// - Start ignored under halt, stop, not enabled
// - Acknowledge set on accept, cleared on zero
module ppc_command_word (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control word access
    input  wire logic             ctrlWe,
    input  wire logic [15:0]      ctrlWdata,
    output var  logic [15:0]      ctrlRdata,
    // Drive context
    input  wire logic             commTick,
    input  wire logic             opEnabled,
    input  wire logic             stopPin,
    input  wire logic [1:0]       wrapModeCfg,
    input  wire logic [1:0]       haltOptionCfg,
    input  wire ppc_pkg::ppc_pos_t positions,
    input  wire logic             moveDone,
    // Commands to the profile generator
    output var  logic             moveStart,
    output var  ppc_pkg::ppc_cmd_t moveCmd,
    output var  logic             moving,
    output var  logic             haltReq,
    output var  logic [1:0]       haltMode,
    output var  ppc_pkg::ppc_cur_t currentSel,
    // Status
    output var  logic             setPointAck
);

    import ppc_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [15:0] ctrlWord;
        logic        startPrev;
        logic [1:0]  guardCnt;
        logic        moving;
        logic        pendValid;
        ppc_cmd_t    pendCmd;
        logic        moveStart;
        ppc_cmd_t    moveCmd;
        logic        ack;
        ppc_cur_t    curSel;
        logic        haltReq;
        logic [1:0]  haltMode;
    } ppc_state_t;

    ppc_state_t state_r;
    ppc_state_t state_nxt;
    logic       stopSync;

    // ==========================================================
    // Stop pin synchroniser
    // ==========================================================
    ppc_sync u_stop_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (stopPin),
        .syncOut (stopSync)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    // Capture the mode bits and raw target at the start strobe
    function automatic ppc_cmd_t captureCmd(input logic [15:0] word,
                                            input logic [1:0]  wrapMode,
                                            input logic [31:0] target);
        ppc_cmd_t c;
        c.wrap      = word[BIT_WRAP];
        c.push      = word[BIT_PUSH];
        c.relative  = word[BIT_RELATIVE];
        c.relActual = word[BIT_REL_BASE];
        c.wrapMode  = wrapMode;
        c.dest      = target;
        return c;
    endfunction : captureCmd

    // Destination is resolved at launch so the base is the present one
    function automatic ppc_cmd_t resolveCmd(input ppc_cmd_t c,
                                            input ppc_pos_t pos);
        ppc_cmd_t o;
        o = c;
        if (!c.relative) begin
            o.dest = c.dest;
        end else if (c.relActual) begin
            o.dest = 32'(c.dest + pos.actual);
        end else begin
            o.dest = 32'(c.dest + pos.commanded);
        end
        return o;
    endfunction : resolveCmd

    // ==========================================================
    // Next state
    // ==========================================================
    logic     haltBit;
    logic     startEdge;
    logic     guardOk;
    logic     blocked;
    logic     stopEvent;
    ppc_cmd_t newCmd;

    always_comb begin
        state_nxt           = state_r;
        state_nxt.moveStart = 1'b0;

        // Bits 9 and 10 are stored for readback but never decoded
        haltBit   = state_r.ctrlWord[BIT_HALT];
        startEdge = state_r.ctrlWord[BIT_START] & ~state_r.startPrev;
        guardOk   = (state_r.guardCnt == HALT_GUARD_DONE);
        blocked   = haltBit | stopSync | ~opEnabled | ~guardOk;
        stopEvent = haltBit | stopSync;
        newCmd    = captureCmd(state_r.ctrlWord, wrapModeCfg, positions.target);

        // Word write from the master; readback shows all bits
        if (ctrlWe) begin
            state_nxt.ctrlWord = ctrlWdata;
        end
        state_nxt.startPrev = state_r.ctrlWord[BIT_START];

        // Halt passes straight on as a level with its stopping option
        state_nxt.haltReq  = haltBit;
        state_nxt.haltMode = haltOptionCfg;

        // Halt release guard counted in communication cycles
        if (haltBit) begin
            state_nxt.guardCnt = HALT_GUARD_RESET;
        end else if (commTick && state_r.guardCnt != HALT_GUARD_DONE) begin
            state_nxt.guardCnt = 2'(state_r.guardCnt + 2'h1);
        end

        // Move completion, then launch of a queued command
        if (moveDone && state_r.moving) begin
            state_nxt.moving = 1'b0;
            state_nxt.curSel = PPC_CUR_STOP;
            if (state_r.pendValid && !stopEvent) begin
                state_nxt.pendValid = 1'b0;
                state_nxt.moving    = 1'b1;
                state_nxt.moveStart = 1'b1;
                state_nxt.moveCmd   = resolveCmd(state_r.pendCmd, positions);
                state_nxt.curSel    = state_r.pendCmd.push ? PPC_CUR_PUSH
                                                           : PPC_CUR_RUN;
            end
        end

        // Halt or stop drops the queue; a push move ends at once
        if (stopEvent) begin
            state_nxt.pendValid = 1'b0;
            if (state_r.moving && state_r.moveCmd.push) begin
                state_nxt.moving = 1'b0;
                state_nxt.curSel = PPC_CUR_STOP;
            end
        end

        // Acknowledge follows the start bit back to zero
        if (!state_r.ctrlWord[BIT_START]) begin
            state_nxt.ack = 1'b0;
        end

        // Accepted start strobe
        if (startEdge && !blocked) begin
            state_nxt.ack = 1'b1;
            if (state_r.moving && !state_r.ctrlWord[BIT_IMMEDIATE] &&
                !(moveDone && !state_r.pendValid)) begin
                state_nxt.pendValid = 1'b1;
                state_nxt.pendCmd   = newCmd;
            end else begin
                // Idle, or replace the running move
                state_nxt.pendValid = 1'b0;
                state_nxt.moving    = 1'b1;
                state_nxt.moveStart = 1'b1;
                state_nxt.moveCmd   = resolveCmd(newCmd, positions);
                state_nxt.curSel    = newCmd.push ? PPC_CUR_PUSH
                                                  : PPC_CUR_RUN;
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '{
                ctrlWord:  CTRL_WORD_RESET,
                startPrev: 1'b0,
                guardCnt:  HALT_GUARD_RESET,
                moving:    1'b0,
                pendValid: 1'b0,
                pendCmd:   '0,
                moveStart: 1'b0,
                moveCmd:   '0,
                ack:       1'b0,
                curSel:    PPC_CUR_STOP,
                haltReq:   1'b0,
                haltMode:  2'h0
            };
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from state flops
    // ==========================================================
    assign ctrlRdata   = state_r.ctrlWord;
    assign moveStart   = state_r.moveStart;
    assign moveCmd     = state_r.moveCmd;
    assign moving      = state_r.moving;
    assign haltReq     = state_r.haltReq;
    assign haltMode    = state_r.haltMode;
    assign currentSel  = state_r.curSel;
    assign setPointAck = state_r.ack;

endmodule : ppc_command_word

`default_nettype wire

// *** ppc_command_word_sva.sv ***
/* Port assertions for the command word interpreter.
   Assumes one clock and the synchronous active high reset of the block. */
`timescale 1ns/1ps
`default_nettype none

module ppc_command_word_sva (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Word and drive context
    input wire logic              ctrlWe,
    input wire logic [15:0]       ctrlWdata,
    input wire logic [15:0]       ctrlRdata,
    input wire logic              opEnabled,
    input wire logic [1:0]        haltOptionCfg,
    // Watched outputs
    input wire logic              moveStart,
    input wire ppc_pkg::ppc_cmd_t moveCmd,
    input wire logic              moving,
    input wire logic              haltReq,
    input wire logic [1:0]        haltMode,
    input wire ppc_pkg::ppc_cur_t currentSel,
    input wire logic              setPointAck
);
    import ppc_pkg::*;
    // ==========================================
    // Properties
    // ==========================================
    // Reset wipes history, so nothing is judged across it
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_word_readback: assert property (
        ctrlWe |=> ctrlRdata == $past(ctrlWdata)) else $error("word readback wrong");
    a_halt_follows: assert property (
        ctrlWe ##2 1 |-> haltReq == $past(ctrlWdata[8], 2)) else $error("halt request wrong");
    a_halt_mode: assert property (
        $changed(haltOptionCfg) |=> haltMode == $past(haltOptionCfg)) else $error("halt mode");
    a_ack_gate: assert property (
        $rose(setPointAck) |-> ctrlRdata[4] && $past(!haltReq && opEnabled))
        else $error("ack while blocked");
    a_ack_clear: assert property (
        ctrlWe && !ctrlWdata[4] |-> ##2 !setPointAck) else $error("ack not cleared");
    a_launch_ack: assert property (
        moveStart && !$past(moving) |-> setPointAck && moving) else $error("launch w/o ack");
    a_launch_bits: assert property (
        moveStart && !$past(moving) |-> moveCmd.wrap == $past(ctrlRdata[14])
        && moveCmd.push == $past(ctrlRdata[13]) && moveCmd.relative == $past(ctrlRdata[6])
        && moveCmd.relActual == $past(ctrlRdata[12])) else $error("command bits wrong");
    a_launch_current: assert property (
        moveStart |-> currentSel == (moveCmd.push ? PPC_CUR_PUSH : PPC_CUR_RUN))
        else $error("run current wrong");
    a_stop_current: assert property (
        !moving |-> currentSel == PPC_CUR_STOP) else $error("standstill current wrong");
    a_halt_push: assert property (
        moving && moveCmd.push && ctrlRdata[8] |-> ##[1:3] !moving) else $error("push kept");
endmodule : ppc_command_word_sva

bind ppc_command_word ppc_command_word_sva chk (
    .clk, .rst, .ctrlWe, .ctrlWdata, .ctrlRdata, .opEnabled, .haltOptionCfg,
    .moveStart, .moveCmd, .moving, .haltReq, .haltMode, .currentSel, .setPointAck
);
`default_nettype wire

// *** ppc_master_model.sv ***
/* Fieldbus master model: resends the control word every comm cycle.
   Assumes the bench calls send from a process aligned to clk. */
`timescale 1ns/1ps
`default_nettype none

module ppc_master_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Cyclic word to the device
    output var  logic        commTick,
    output var  logic        ctrlWe,
    output var  logic [15:0] ctrlWdata
);
    import ppc_pkg::*;
    // ==========================================
    // Cyclic writer
    // ==========================================
    logic [1:0]  cycDiv_r = 2'h0;
    logic [15:0] word_r   = 16'h0000;
    // One comm cycle per four clocks; resending keeps an unchanged word edge-free
    always @(posedge clk) begin
        cycDiv_r  <= rst ? 2'h0 : cycDiv_r + 2'h1;
        commTick  <= !rst && cycDiv_r == 2'h3;
        ctrlWe    <= !rst && cycDiv_r == 2'h3;
        ctrlWdata <= word_r;
    end
    // Mode bits settle with the strobe low; a halt release waits five comm cycles
    task automatic send(input logic [15:0] w);
        if (w[BIT_START] || (word_r[BIT_HALT] && !w[BIT_HALT])) begin
            word_r <= w & ~16'h0010;
            repeat (20) @(posedge clk);
        end
        word_r <= w;
        repeat (8) @(posedge clk);
    endtask : send
endmodule : ppc_master_model
`default_nettype wire

// *** ppc_command_word_bench.sv ***
/* Self-checking bench for ppc_command_word; the master model writes the
   word, the bench plays profile generator and drive context. */
`timescale 1ns/1ps
`default_nettype none

module ppc_command_word_bench;
    import ppc_pkg::*;
    logic        clk, rst, ctrlWe, commTick, opEnabled, stopPin, moveDone;
    logic        moveStart, moving, haltReq, setPointAck;
    logic [15:0] ctrlWdata, ctrlRdata;
    logic [1:0]  wrapModeCfg, haltOptionCfg, haltMode;
    ppc_pos_t    positions;
    ppc_cmd_t    moveCmd, lastCmd;
    ppc_cur_t    currentSel;
    int          bad_count = 0, comparisons = 0, launches = 0;
    logic [15:0] modeWord [4] = '{16'h0000, 16'h0040, 16'h1040, 16'h4600};
    logic [31:0] modeDest [4] = '{32'h100, 32'h1100, 32'h2100, 32'h100};

    // ==========================================
    // Harness
    // ==========================================
    ppc_master_model master (.clk, .rst, .commTick, .ctrlWe, .ctrlWdata);
    ppc_command_word DUT (.clk, .rst, .ctrlWe, .ctrlWdata, .ctrlRdata, .commTick,
        .opEnabled, .stopPin, .wrapModeCfg, .haltOptionCfg, .positions, .moveDone,
        .moveStart, .moveCmd, .moving, .haltReq, .haltMode, .currentSel, .setPointAck);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Launch pulses last one cycle, so they are counted as they pass
    always @(posedge clk) if (moveStart === 1'b1) begin
        launches++;
        lastCmd = moveCmd;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finishMove();
        moveDone <= 1'b1;
        @(posedge clk);
        moveDone <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : finishMove
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        {rst, opEnabled, moveDone, stopPin} = 4'b1100;
        wrapModeCfg = 2'h2;
        haltOptionCfg = 2'h1;
        positions = '{target: 32'h100, commanded: 32'h1000, actual: 32'h2000};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        chk("rdata", ctrlRdata, 32'h0);
        // Absolute, both relative bases and wrap moves from standstill
        for (int i = 0; i < 4; i++) begin
            // Settings and target differ per pass so a stuck capture shows
            wrapModeCfg      <= 2'(i);
            haltOptionCfg    <= 2'(3 - i);
            positions.target <= 32'(32'h100 + i);
            master.send(modeWord[i] | 16'h0010);
            chk("launch", launches, i + 1);
            chk("dest", lastCmd.dest, modeDest[i] + 32'(i));
            chk("wrap", lastCmd.wrap, modeWord[i][14]);
            chk("wrapMode", lastCmd.wrapMode, i);
            chk("haltModeLoop", haltMode, 3 - i);
            chk("ack", setPointAck, 32'h1);
            master.send(modeWord[i]);
            chk("ackOff", setPointAck, 32'h0);
            chk("rdata", ctrlRdata, modeWord[i]);
            finishMove();
        end
        // Push move ended by halt, then a start under halt
        master.send(16'h2010);
        chk("pushCur", currentSel, PPC_CUR_PUSH);
        master.send(16'h2110);
        chk("halted", moving, 32'h0);
        chk("haltLaunch", launches, 32'd5);
        chk("haltAck", setPointAck, 32'h0);
        chk("haltReq", haltReq, 32'h1);
        // Release, queued start, then replacements
        master.send(16'h0010);
        chk("resume", launches, 32'd6);
        master.send(16'h0010);
        chk("queued", launches, 32'd6);
        // Target moves while queued; the strobe's target must be kept
        positions.target <= 32'h777;
        finishMove();
        chk("dequeued", launches, 32'd7);
        chk("queuedDest", lastCmd.dest, 32'h103);
        master.send(16'h2030);
        chk("replace", launches, 32'd8);
        chk("replaceDest", lastCmd.dest, 32'h777);
        master.send(16'h2030);
        chk("replacePush", launches, 32'd9);
        // Stop input and a disabled drive both block starts
        stopPin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("stopEnd", moving, 32'h0);
        master.send(16'h0010);
        chk("stopBlock", launches, 32'd9);
        stopPin <= 1'b0;
        opEnabled <= 1'b0;
        haltOptionCfg <= 2'h3;
        master.send(16'h0010);
        chk("offBlock", launches, 32'd9);
        chk("haltMode", haltMode, 32'h3);
        end_of_test();
    end
    // Whole run is under a thousand clocks; this cuts a hang
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule : ppc_command_word_bench
`default_nettype wire
